// File: wws_regs.vh
// Constants for the windowed watchdog supervisor: timing in base ticks.
// Assumes a 40 MHz core clock and a tick divider set by a module parameter.
`ifndef WWS_REGS_VH
`define WWS_REGS_VH

// Core clock period in ns.
`define WWS_CLK_PERIOD_NS   25
// Comparator reaction time, 5 us, and its cycle count.
`define WWS_REACT_US        5
`define WWS_REACT_CYC       ((`WWS_REACT_US * 1000) / `WWS_CLK_PERIOD_NS)
// Base tick is 1/40 of the watchdog period: 2.5 ms nominal = 100000 cycles.
`define WWS_TICK_US         2500
`define WWS_TICK_CYC        ((`WWS_TICK_US * 1000) / `WWS_CLK_PERIOD_NS)
// Durations in base ticks (period = 40 ticks = 100 ms).
`define WWS_PERIOD_TICKS    40
`define WWS_CLOSED_TICKS    32
`define WWS_OPEN_TICKS      16
`define WWS_PULSE_TICKS     1
// Consecutive good services needed to enable.
`define WWS_GOOD_SERVICES   3

`endif

// File: wws_tick_div.v
// Base tick divider: one-cycle enable pulse every DIV cycles.
// Assumes a single free-running clock; restart clears the phase.
`timescale 1ns/1ps
`default_nettype none

module wws_tick_div #(
    parameter DIV = 100000
) (
    input  wire mclk_i,      // Core clock.
    input  wire reset_n_i,   // Async reset, active low.
    input  wire restart_i,   // Realign the tick phase.
    output reg  tick_o       // One-cycle tick pulse.
);

    reg [31:0] cnt_reg;

    // ======================================================================
    // Divider counter.
    // Restart aligns a window begun by a clear edge or by power recovery to that event; timeouts keep the free phase.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_reg <= 32'h0;
            tick_o  <= 1'b0;
        end
        else if (restart_i)
        begin
            cnt_reg <= 32'h0;
            tick_o  <= 1'b0;
        end
        else if (cnt_reg == DIV - 1)
        begin
            cnt_reg <= 32'h0;
            tick_o  <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
            tick_o  <= 1'b0;
        end
    end

endmodule // wws_tick_div

`default_nettype wire

// File: wws_supervisor.v
// Windowed watchdog supervisor: power-on delay, power-down reset,
// closed/open service windows, reset pulses and a system enable output.
// Assumes monitor_in is the comparator result (high = above threshold)
// and supply_ok_i is high once the supply is valid; both asynchronous.
//
// Contract
// - Hold reset low through power-on delay.
// - Comparator low forces power-down reset.
// - All times derive from one tick base. (The comparator filter counts REACT_CYC core cycles instead.)
// - Watchdog reset pulse is period over forty.
// - Closed window follows every timer reset.
// - Open window follows, twice fraction long.
// - No service by window end: pulse, restart.
// - Open window service restarts closed window.
// - Closed window service asserts reset, restarts.
// - Unserviced: pulses repeat each window plus pulse.
// - Ignore clear pulses during power-on delay.
// - Delay end releases reset, starts closed window.
// - Long comparator low overrides, disables enable.
// - After voltage reset, ignore clears until powered.
// - Enable inactive whenever reset is asserted.
// - Enable after three consecutive good services.
`timescale 1ns/1ps
`default_nettype none
`include "wws_regs.vh"

module wws_supervisor #(
    parameter TICK_CYC   = `WWS_TICK_CYC,      // Cycles per base tick.
    parameter REACT_CYC  = `WWS_REACT_CYC,     // Comparator filter cycles.
    parameter POR_TICKS  = `WWS_PERIOD_TICKS,  // Power-on delay in ticks.
    parameter CLS_TICKS  = `WWS_CLOSED_TICKS,  // Closed window in ticks.
    parameter OPN_TICKS  = `WWS_OPEN_TICKS,    // Open window in ticks.
    parameter PLS_TICKS  = `WWS_PULSE_TICKS    // Reset pulse in ticks.
) (
    input  wire mclk_i,          // Core clock, 40 MHz.
    input  wire reset_n_i,       // Async reset, active low.
    input  wire supply_ok_i,     // Supply valid, active high, async.
    input  wire monitor_in_i,    // Comparator: high above threshold, async.
    input  wire wd_clear_in_i,   // Service input, falling edge, async.
    output wire reset_out_n_o,   // Reset output level, active low.
    output wire reset_out_oe_o,  // Open-drain enable: high drives low.
    output reg  enable_out_n_o   // System enable, active low.
);

    // ======================================================================
    // State codes.
    localparam [2:0] ST_POR    = 3'h0;
    localparam [2:0] ST_CLOSED = 3'h1;
    localparam [2:0] ST_OPEN   = 3'h2;
    localparam [2:0] ST_PULSE  = 3'h3;
    localparam [2:0] ST_DOWN   = 3'h4;

    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [7:0]  tcnt_reg;
    reg [7:0]  tcnt_next;
    reg [1:0]  good_reg;
    reg [1:0]  good_next;
    reg        rst_reg;
    reg        rst_next;
    reg        restart;
    reg [31:0] flt_reg;
    reg        vlow_reg;
    reg [2:0]  clr_sync_reg;
    reg        clr_level_reg;
    reg [2:0]  mon_sync_reg;
    reg        mon_level_reg;
    reg [2:0]  sup_sync_reg;
    reg        sup_level_reg;
    wire       tick;
    wire       clr_fall;
    wire       pwr_good;

    // ======================================================================
    // Helpers shared by the synchronisers and every timed state.

    // A synchronised level counts once stages two and three agree.
    function wws_agree;
        input [2:0] stages;
        begin
            wws_agree = (stages[1] == stages[2]);
        end
    endfunction

    // High on the last tick of a span of len ticks.
    // Comparing at 32 bits keeps a wide parameter from being cut silently.
    function wws_last_tick;
        input [7:0]  cnt;
        input [31:0] len;
        begin
            wws_last_tick = ({24'h000000, cnt} == (len - 32'h1));
        end
    endfunction

    // Next tick count; eight bits hold the longest span of forty ticks.
    function [7:0] wws_next_cnt;
        input [7:0] cnt;
        begin
            wws_next_cnt = cnt + 8'h1;
        end
    endfunction

    // ======================================================================
    // Input synchronisers: a change counts once stages two and three agree.
    // Three stages cost four cycles of latency, far below the shortest window.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            clr_sync_reg  <= 3'h7;
            clr_level_reg <= 1'b1;
            mon_sync_reg  <= 3'h0;
            mon_level_reg <= 1'b0;
            sup_sync_reg  <= 3'h0;
            sup_level_reg <= 1'b0;
        end
        else
        begin
            clr_sync_reg <= {clr_sync_reg[1:0], wd_clear_in_i};
            mon_sync_reg <= {mon_sync_reg[1:0], monitor_in_i};
            sup_sync_reg <= {sup_sync_reg[1:0], supply_ok_i};
            if (wws_agree(clr_sync_reg))
            begin
                clr_level_reg <= clr_sync_reg[2];
            end
            if (wws_agree(mon_sync_reg))
            begin
                mon_level_reg <= mon_sync_reg[2];
            end
            if (wws_agree(sup_sync_reg))
            begin
                sup_level_reg <= sup_sync_reg[2];
            end
        end
    end

    // Falling edge of the filtered clear level.
    assign clr_fall = clr_level_reg && (clr_sync_reg[2] == 1'b0) &&
                      (clr_sync_reg[1] == 1'b0);

    // ======================================================================
    // Comparator reaction filter: low must persist REACT_CYC cycles.
    // Short glitches on the monitor do not cause a power-down reset.
    // A low supply flag takes the same path, so both share one reaction time.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flt_reg  <= 32'h0;
            vlow_reg <= 1'b1;
        end
        else if (mon_level_reg && sup_level_reg)
        begin
            flt_reg  <= 32'h0;
            vlow_reg <= 1'b0;
        end
        else if (flt_reg >= REACT_CYC - 1)
        begin
            vlow_reg <= 1'b1;
        end
        else
        begin
            flt_reg <= flt_reg + 32'h1;
        end
    end

    // Power is good only once the low indication has cleared.
    assign pwr_good = !vlow_reg;

    // ======================================================================
    // Single tick base for every window, pulse and delay; the comparator filter counts core cycles.
    wws_tick_div #(
        .DIV       (TICK_CYC)
    ) u_tick (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .restart_i (restart),
        .tick_o    (tick)
    );

    // ======================================================================
    // Supervisor state machine.
    // The tick phase restarts only where a window is anchored to a clear
    // edge or to power recovery; timeouts run on from the free tick.
    always @*
    begin
        state_next = state_reg;
        tcnt_next  = tcnt_reg;
        good_next  = good_reg;
        rst_next   = rst_reg;
        restart    = 1'b0;
        case (state_reg)
            ST_DOWN:
            begin
                // Clears are ignored until power recovers and the
                // following power-on delay has run out.
                rst_next  = 1'b1;
                good_next = 2'h0;
                if (pwr_good)
                begin
                    state_next = ST_POR;
                    tcnt_next  = 8'h0;
                    restart    = 1'b1;
                end
            end
            ST_POR:
            begin
                // Clear edges have no effect here.
                // Limitation: an edge still inside the synchroniser when the
                // delay ends reaches the closed window as an early service.
                rst_next = 1'b1;
                if (tick)
                begin
                    if (wws_last_tick(tcnt_reg, POR_TICKS))
                    begin
                        state_next = ST_CLOSED;
                        tcnt_next  = 8'h0;
                        rst_next   = 1'b0;
                    end
                    else
                    begin
                        tcnt_next = wws_next_cnt(tcnt_reg);
                    end
                end
            end
            ST_CLOSED:
            begin
                if (clr_fall)
                begin
                    // Early service is a fault.
                    state_next = ST_PULSE;
                    tcnt_next  = 8'h0;
                    rst_next   = 1'b1;
                    good_next  = 2'h0;
                    restart    = 1'b1;
                end
                else if (tick)
                begin
                    if (wws_last_tick(tcnt_reg, CLS_TICKS))
                    begin
                        state_next = ST_OPEN;
                        tcnt_next  = 8'h0;
                    end
                    else
                    begin
                        tcnt_next = wws_next_cnt(tcnt_reg);
                    end
                end
            end
            ST_OPEN:
            begin
                if (clr_fall)
                begin
                    state_next = ST_CLOSED;
                    tcnt_next  = 8'h0;
                    restart    = 1'b1;
                    if (good_reg != `WWS_GOOD_SERVICES)
                    begin
                        good_next = good_reg + 2'h1;
                    end
                end
                else if (tick)
                begin
                    if (wws_last_tick(tcnt_reg, OPN_TICKS))
                    begin
                        state_next = ST_PULSE;
                        tcnt_next  = 8'h0;
                        rst_next   = 1'b1;
                        good_next  = 2'h0;
                    end
                    else
                    begin
                        tcnt_next = wws_next_cnt(tcnt_reg);
                    end
                end
            end
            ST_PULSE:
            begin
                // Pulse length is period over forty; clears ignored.
                if (tick)
                begin
                    if (wws_last_tick(tcnt_reg, PLS_TICKS))
                    begin
                        state_next = ST_CLOSED;
                        tcnt_next  = 8'h0;
                        rst_next   = 1'b0;
                    end
                    else
                    begin
                        tcnt_next = wws_next_cnt(tcnt_reg);
                    end
                end
            end
            default:
            begin
                state_next = ST_DOWN;
                rst_next   = 1'b1;
            end
        endcase
        // A low supply overrides everything else.
        if (!pwr_good)
        begin
            state_next = ST_DOWN;
            rst_next   = 1'b1;
            good_next  = 2'h0;
            tcnt_next  = 8'h0;
        end
    end

    // ======================================================================
    // State registers and enable output.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg      <= ST_DOWN;
            tcnt_reg       <= 8'h0;
            good_reg       <= 2'h0;
            rst_reg        <= 1'b1;
            enable_out_n_o <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            tcnt_reg  <= tcnt_next;
            good_reg  <= good_next;
            rst_reg   <= rst_next;
            // Enable only with reset released and three good services.
            // Built from the next-state values so that enable drops on the
            // very edge that asserts reset, never one cycle late.
            enable_out_n_o <= !(!rst_next &&
                              (good_next == `WWS_GOOD_SERVICES));
        end
    end

    // Open-drain reset pin: drive low while asserted.
    // Level and drive enable come from one flop, so they never disagree.
    assign reset_out_oe_o = rst_reg;
    assign reset_out_n_o  = !rst_reg;

endmodule // wws_supervisor

`default_nettype wire

// File: wws_asserts.sv
// Checker of the supervisor's pin timing, bound to its top module.
// Assumes one clock; the fixed repetitions suit a ten-cycle tick.
`timescale 1ns/1ps
`default_nettype none
module wws_chk #(
    parameter int TICK_CYC  = 10, // Cycles per tick.
    parameter int POR_TICKS = 40, // Power-on delay ticks.
    parameter int CLS_TICKS = 32, // Closed window ticks.
    parameter int OPN_TICKS = 16  // Open window ticks.
) (
    input wire logic mclk_i,        // Clock.
    input wire logic reset_n_i,     // Reset, active low.
    input wire logic supply_ok_i,   // Supply valid.
    input wire logic monitor_in_i,  // Comparator.
    input wire logic wd_clear_in_i, // Service input.
    input wire logic reset_out_n_o, // Reset output.
    input wire logic enable_out_n_o // Enable output.
);
    localparam int CLS_C = CLS_TICKS * TICK_CYC;
    localparam int WIN_C = CLS_C + OPN_TICKS * TICK_CYC;
    logic        rst_q, clr_q, run_q, por_q;
    logic [11:0] since_q, low_q;
    logic [5:0]  age_q;
    wire         pwr = supply_ok_i & monitor_in_i;
    wire         rel = reset_out_n_o & ~rst_q;
    wire         svc = clr_q & ~wd_clear_in_i;
    // =========================================================
    // Ages: since release or service, since service, and of reset with power good.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_q   <= 1'b0;
            clr_q   <= 1'b1;
            run_q   <= 1'b0;
            por_q   <= 1'b1;
            since_q <= 12'h000;
            low_q   <= 12'h000;
            age_q   <= 6'h00;
        end
        else
        begin
            rst_q   <= reset_out_n_o;
            clr_q   <= wd_clear_in_i;
            run_q   <= pwr & (run_q | rel);
            por_q   <= ~pwr | (por_q & ~rel);
            since_q <= (rel | svc) ? 12'h000 : since_q + {11'h000, ~&since_q};
            low_q   <= (reset_out_n_o | ~pwr) ? 12'h000 : low_q + 12'h001;
            age_q   <= svc ? 6'h00 : age_q + {5'h00, ~&age_q};
        end
    end
    // =========================================================
    // Properties; margins of two ticks absorb the input synchroniser.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    property p_en_off; !reset_out_n_o |-> enable_out_n_o; endproperty
    a_en_off: assert property (p_en_off) else $error("enable on during reset");
    property p_vlow; (!pwr)[*8] ##1 (!pwr)[*8] |-> !reset_out_n_o && enable_out_n_o; endproperty
    a_vlow: assert property (p_vlow) else $error("no reset on low supply");
    property p_por; $rose(reset_out_n_o) && por_q |-> low_q >= POR_TICKS * TICK_CYC - TICK_CYC;
    endproperty
    a_por: assert property (p_por) else $error("power-on delay short");
    property p_pulse; $fell(reset_out_n_o) && run_q && pwr |->
        (!reset_out_n_o)[*8] ##[1:4] reset_out_n_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse width wrong");
    property p_early; svc && reset_out_n_o && run_q && since_q < CLS_C - 2 * TICK_CYC |->
        ##[2:12] !reset_out_n_o; endproperty
    a_early: assert property (p_early) else $error("early service not punished");
    property p_timeout; reset_out_n_o && rst_q |-> since_q <= WIN_C + 2 * TICK_CYC; endproperty
    a_timeout: assert property (p_timeout) else $error("window overran");
    property p_spont; $fell(reset_out_n_o) && run_q && pwr && age_q > 6'h14 |->
        since_q >= WIN_C - 2 * TICK_CYC; endproperty
    a_spont: assert property (p_spont) else $error("reset before window end");
    property p_enfall; $fell(enable_out_n_o) |-> reset_out_n_o && age_q < 6'h0C; endproperty
    a_enfall: assert property (p_enfall) else $error("enable without service");
    c_en: cover property ($fell(enable_out_n_o));
    c_early: cover property (svc && run_q && since_q < CLS_C - 2 * TICK_CYC);
    c_vlow: cover property ((!pwr)[*8]);
endmodule // wws_chk
bind wws_supervisor wws_chk #(.TICK_CYC(TICK_CYC), .POR_TICKS(POR_TICKS),
    .CLS_TICKS(CLS_TICKS), .OPN_TICKS(OPN_TICKS)) u_chk (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .supply_ok_i(supply_ok_i), .monitor_in_i(monitor_in_i),
    .wd_clear_in_i(wd_clear_in_i), .reset_out_n_o(reset_out_n_o),
    .enable_out_n_o(enable_out_n_o));
`default_nettype wire

// File: wws_host.sv
// Host model: pulses the service pin a set delay after release or service.
// Assumes the pin idles high through its pull-up between pulses.
`timescale 1ns/1ps
`default_nettype none
module wws_host (
    input  wire logic       mclk_i,        // Clock.
    input  wire logic       reset_out_n_i, // Reset from the supervisor.
    input  wire logic       svc_en_i,      // Service enable.
    input  wire logic       spam_i,        // Pulse while held in reset.
    input  wire logic [9:0] svc_dly_i,     // Service delay in cycles.
    output var  logic       wd_clear_o     // Service pin.
);
    logic [9:0] cnt_q = 10'h000;
    logic [9:0] dly_q = 10'h000;
    logic [2:0] pw_q  = 3'h0;
    logic       rst_q = 1'b0;
    // =========================================================
    // The delay is latched at each restart, so the bench may change it freely.
    always_ff @(posedge mclk_i)
    begin
        rst_q <= reset_out_n_i;
        cnt_q <= cnt_q + 10'h001;
        pw_q  <= (pw_q != 3'h0) ? pw_q - 3'h1 : 3'h0;
        if (reset_out_n_i && (!rst_q || (svc_en_i && cnt_q == dly_q)))
        begin
            cnt_q <= 10'h000;
            dly_q <= svc_dly_i;
            pw_q  <= rst_q ? 3'h6 : 3'h0;
        end
        else if (spam_i && !reset_out_n_i && cnt_q[3:0] == 4'h0)
            pw_q  <= 3'h6;
    end
    assign wd_clear_o = (pw_q == 3'h0);
endmodule // wws_host
`default_nettype wire

// File: tb_windowed_watchdog_supervisor.sv
// Bench: drives power and service, queues expected output states, compares.
// Assumes the host model drives the service pin.
`timescale 1ns/1ps
`default_nettype none
module tb_windowed_watchdog_supervisor;
    logic        mclk_i;
    logic        reset_n_i;
    logic        supply_ok_i;
    logic        monitor_in_i;
    logic        svc_en;
    logic        spam;
    logic [9:0]  svc_dly;
    logic [1:0]  note;
    logic [31:0] seed         = 32'h3A82;
    logic [1:0]  last_q       = 2'b01;
    logic [1:0]  exp_q[$];
    int          fails        = 0;
    int          checks       = 0;
    wire         wd_clear, reset_out_n_o, reset_out_oe_o, enable_out_n_o;
    wws_supervisor #(.TICK_CYC(32'hA), .REACT_CYC(32'h4)) DUT (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .supply_ok_i(supply_ok_i), .monitor_in_i(monitor_in_i),
        .wd_clear_in_i(wd_clear), .reset_out_n_o(reset_out_n_o),
        .reset_out_oe_o(reset_out_oe_o), .enable_out_n_o(enable_out_n_o));
    wws_host u_host (.mclk_i(mclk_i), .reset_out_n_i(reset_out_n_o), .svc_en_i(svc_en),
        .spam_i(spam), .svc_dly_i(svc_dly), .wd_clear_o(wd_clear));
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // =========================================================
    // Helpers.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp_out(input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] reset_enable expected %b seen %b", e, g);
        end
    endtask
    task automatic cmp_oe(input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] reset_drive expected %b seen %b", e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for the queued changes; running out is a mismatch.
    task automatic drain(input int n);
        for (int i = 0; i < n && exp_q.size() > 0; i++)
            @(posedge mclk_i);
        if (exp_q.size() > 0)
        begin
            fails++;
            $display("[ERR] pending expected 0 seen %0d", exp_q.size());
            complete_run();
        end
    endtask
    // Watcher: sampled mid-cycle so outputs have settled; any change pops a note.
    always @(negedge mclk_i)
    begin
        if (reset_n_i === 1'b1 && {reset_out_n_o, enable_out_n_o} !== last_q)
        begin
            last_q = {reset_out_n_o, enable_out_n_o};
            note   = (exp_q.size() > 0) ? exp_q.pop_front() : 2'bxx;
            cmp_out(note, last_q);
            cmp_oe(~note[1], reset_out_oe_o);
        end
    end
    // =========================================================
    // Main sequence.
    initial
    begin
        reset_n_i    <= 1'b0;
        supply_ok_i  <= 1'b1;
        monitor_in_i <= 1'b1;
        svc_en       <= 1'b0;
        spam         <= 1'b0;
        svc_dly      <= 10'h186;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        exp_q.push_back(2'b11);
        drain(700);
        svc_en <= 1'b1;
        exp_q.push_back(2'b10);
        drain(1400);
        // Random service points inside the open window; no change is expected.
        repeat (4)
        begin
            seed = lfsr(seed);
            svc_dly <= 10'h14F + 10'(seed % 32'h83);
            repeat (470) @(posedge mclk_i);
        end
        svc_dly <= 10'h064;
        exp_q.push_back(2'b01);
        exp_q.push_back(2'b11);
        drain(1100);
        svc_en <= 1'b0;
        svc_dly <= 10'h186;
        repeat (2)
        begin
            exp_q.push_back(2'b01);
            exp_q.push_back(2'b11);
        end
        drain(1100);
        svc_en <= 1'b1;
        exp_q.push_back(2'b10);
        drain(1500);
        // Comparator drop, then supply drop, with clear pulses during power-on delay.
        for (int k = 0; k < 2; k++)
        begin
            spam <= 1'b1;
            {supply_ok_i, monitor_in_i} <= (k == 0) ? 2'b10 : 2'b01;
            exp_q.push_back(2'b01);
            drain(60);
            repeat (40) @(posedge mclk_i);
            {supply_ok_i, monitor_in_i} <= 2'b11;
            exp_q.push_back(2'b11);
            // Clear pulses stop well inside the delay, so none is still in the
            // synchroniser when the closed window opens.
            repeat (200) @(posedge mclk_i);
            spam <= 1'b0;
            drain(500);
            exp_q.push_back(2'b10);
            drain(1500);
        end
        complete_run();
    end
endmodule // tb_windowed_watchdog_supervisor
`default_nettype wire
